// *** rtm_retimer.sv ***
// Purpose: mode control, strap capture, de-skew path and I2C target of a 4-lane retimer
// Assumes: strap pins arrive as level codes 00 low, 01 mid, 11 high from a level sensor
// Notes: hs data arrives as two bits per lane per forwarded clock (double data rate)
`timescale 1ns/10ps
`include "rtm_map.svh"
module rtm_retimer #(
    parameter logic [63:0] ID_STRING = 64'h0102030405060708, // arbitrary value
    parameter logic [7:0] DEV_REV = 8'h01 // arbitrary value
) (
    input wire logic clk_sys_in, // system clock, 125 MHz
    input wire logic resetn_in, // shutdown_reset_n pin, low = shutdown
    input wire logic hs_clk_in, // forwarded HS clock of the input clock lane
    input wire logic [1:0] eq_strap_level_in, // equalizer strap level code
    input wire logic [1:0] erc_strap_level_in, // edge-rate strap level code
    input wire logic [1:0] swing_strap_pin_in, // swing strap level code
    input wire logic [1:0] preemph_strap_pin_hi_in, // second pre-emphasis strap level code
    input wire logic equalizer_strap_clock_pin_in, // I2C clock
    input wire logic edge_rate_strap_data_pin_in, // I2C data, bus level
    output logic edge_rate_strap_data_pin_out, // I2C data drive value, always 0
    output logic edge_rate_strap_data_pin_oe_out, // I2C data pull low
    input wire rtm_pkg::rtm_lp_s input_data_lanes_lp_in, // LP states of input data lanes
    input wire logic [1:0] input_clock_lane_lp_in, // LP state of input clock lane
    input wire logic [1:0] output_lane_zero_lp_in, // LP state seen on output lane zero
    output rtm_pkg::rtm_lp_s output_data_lanes_lp_out, // LP states driven on output lanes
    output logic output_lane_zero_oe_out, // output lane zero LP driver on
    output logic [1:0] output_clock_lane_lp_out, // LP state of output clock lane
    output logic [1:0] input_lane_zero_lp_out, // reverse LP state to input lane zero
    output logic input_lane_zero_oe_out, // input lane zero LP driver on
    input wire rtm_pkg::rtm_hs_s input_data_lanes_hs_in, // HS bits, link clock domain
    output rtm_pkg::rtm_hs_s output_data_lanes_hs_out, // retimed HS bits
    output logic output_clock_lane_en_out, // forwarded HS clock enable
    output logic hs_term_en_out, // HS rx and tx terminations on
    output logic hs_logic_en_out, // HS logic powered
    output logic [3:0] rx_equalizer_out, // {clock lane, data lane} equalizer codes
    output logic [1:0] hs_edge_rate_out, // HS edge-rate code
    output logic [3:0] lp_edge_rate_out, // {input lane zero, output lanes} LP edge codes
    output logic [1:0] tx_preemphasis_out, // {swing 220 mV, pre-emphasis 2.5 dB}
    output rtm_pkg::rtm_mode_e mode_out // current operating mode
);
    import rtm_pkg::*;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    localparam int SW = 22;
    logic [SW-1:0] raw_w;
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    assign raw_w = {equalizer_strap_clock_pin_in, edge_rate_strap_data_pin_in,
                    input_data_lanes_lp_in, input_clock_lane_lp_in, output_lane_zero_lp_in,
                    eq_strap_level_in, erc_strap_level_in, swing_strap_pin_in,
                    preemph_strap_pin_hi_in};
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            // i2c lines reset to their idle high level so no false edge follows reset
            sync1 <= {2'b11, {(SW - 2){1'b0}}};
            sync2 <= {2'b11, {(SW - 2){1'b0}}};
        end
        else
        begin
            sync1 <= raw_w;
            sync2 <= sync1;
        end
    end
    wire logic scl_w = sync2[21];
    wire logic sda_w = sync2[20];
    rtm_lp_s lp_in_w;
    assign lp_in_w = sync2[19:12];
    wire logic [1:0] lane0_w = sync2[13:12];
    wire logic [1:0] clk_lp_w = sync2[11:10];
    wire logic [1:0] rev_w = sync2[9:8];
    wire logic [1:0] eq_lv_w = sync2[7:6];
    wire logic [1:0] erc_lv_w = sync2[5:4];
    wire logic [1:0] sw_lv_w = sync2[3:2];
    wire logic [1:0] pre_lv_w = sync2[1:0];

    // ----------------------------------------
    // strap decoding
    // ----------------------------------------
    // 0 low, 1 mid, 2 high; the unused code 10 counts as mid
    function automatic logic [1:0] f_level(input logic [1:0] c);
        f_level = c[1] & c[0] ? 2'h2 : {1'b0, c[1] | c[0]};
    endfunction : f_level
    wire logic [1:0] eq_lvl_w = f_level(eq_lv_w);
    wire logic [1:0] erc_lvl_w = f_level(erc_lv_w);
    wire logic [1:0] sw_lvl_w = f_level(sw_lv_w);
    wire logic [1:0] pre_lvl_w = f_level(pre_lv_w);
    wire logic [1:0] eq_code_w = eq_lvl_w == 2'h0 ? `RTM_EQ_0DB :
                                 eq_lvl_w == 2'h1 ? `RTM_EQ_2P5DB : `RTM_EQ_5DB;
    wire logic [1:0] hserc_w = erc_lvl_w == 2'h0 ? `RTM_HSERC_200PS :
                               erc_lvl_w == 2'h1 ? `RTM_HSERC_150PS : `RTM_HSERC_250PS;
    wire logic [1:0] lperc_w = (sw_lvl_w == 2'h1 && pre_lvl_w == 2'h0) ||
                               (sw_lvl_w == 2'h0 && pre_lvl_w != 2'h0) ? `RTM_LPERC_27NS :
                               pre_lvl_w == 2'h0 ? `RTM_LPERC_18NS : `RTM_LPERC_21NS;
    wire logic pre_w = pre_lvl_w == 2'h2;
    wire logic swing_w = sw_lvl_w == 2'h2 || (sw_lvl_w == 2'h0 && pre_lvl_w == 2'h2);

    // ----------------------------------------
    // strap capture after reset release
    // ----------------------------------------
    logic [1:0] settle;
    logic strap_done;
    wire logic strap_load_w = !strap_done && settle == `RTM_STRAP_SETTLE;
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            settle <= '0;
            strap_done <= 1'b0;
        end
        else
        begin
            settle <= strap_done ? settle : settle + 2'h1; // synchronisers fill first
            strap_done <= strap_done | strap_load_w;
        end
    end

    // ----------------------------------------
    // mode machine on lane zero LP states
    // ----------------------------------------
    rtm_mode_e mode;
    rtm_mode_e next_mode;
    always_comb
    begin
        next_mode = mode;
        case (mode)
            RTM_LP: next_mode = lane0_w == `RTM_LP01 ? RTM_HSRQ :
                                lane0_w == `RTM_LP10 ? RTM_ESC1 : RTM_LP;
            RTM_HSRQ: next_mode = lane0_w == `RTM_LP00 ? RTM_HS :
                                  lane0_w == `RTM_LP11 ? RTM_LP : RTM_HSRQ;
            RTM_HS: next_mode = lane0_w == `RTM_LP11 ? RTM_LP : RTM_HS;
            RTM_ESC1: next_mode = lane0_w == `RTM_LP00 ? RTM_ESC2 :
                                  lane0_w == `RTM_LP11 ? RTM_LP : RTM_ESC1;
            RTM_ESC2: next_mode = lane0_w == `RTM_LP01 ? RTM_ESC3 :
                                  lane0_w == `RTM_LP10 ? RTM_TA1 :
                                  lane0_w == `RTM_LP11 ? RTM_LP : RTM_ESC2;
            RTM_ESC3: next_mode = lane0_w == `RTM_LP00 ? RTM_ULPS :
                                  lane0_w == `RTM_LP11 ? RTM_LP : RTM_ESC3;
            RTM_ULPS: next_mode = lane0_w == `RTM_LP11 ? RTM_LP : RTM_ULPS;
            RTM_TA1: next_mode = lane0_w == `RTM_LP00 ? RTM_REV :
                                 lane0_w == `RTM_LP11 ? RTM_LP : RTM_TA1;
            RTM_REV: next_mode = rev_w == `RTM_LP10 ? RTM_REVX : RTM_REV;
            RTM_REVX: next_mode = rev_w == `RTM_LP00 ? RTM_LP : RTM_REVX;
            default: next_mode = RTM_LP;
        endcase
    end
    wire logic rev_w2 = mode == RTM_REV || mode == RTM_REVX;
    rtm_lp_s next_lp_w;
    assign next_lp_w = (mode == RTM_HS || rev_w2) ? '0 : lp_in_w;
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            mode <= RTM_LP;
            output_data_lanes_lp_out <= '0;
            output_clock_lane_lp_out <= '0;
            input_lane_zero_lp_out <= '0;
            input_lane_zero_oe_out <= 1'b0;
            output_lane_zero_oe_out <= 1'b1; // shutdown actively drives LP00
            hs_term_en_out <= 1'b0;
            hs_logic_en_out <= 1'b0;
        end
        else
        begin
            mode <= next_mode;
            output_data_lanes_lp_out <= next_lp_w;
            output_clock_lane_lp_out <= clk_lp_w;
            input_lane_zero_lp_out <= rev_w;
            input_lane_zero_oe_out <= rev_w2;
            output_lane_zero_oe_out <= !rev_w2;
            hs_term_en_out <= next_mode == RTM_HS;
            hs_logic_en_out <= next_mode != RTM_ULPS;
        end
    end
    assign mode_out = mode;

    // ----------------------------------------
    // de-skew path on the link clock
    // ----------------------------------------
    logic [2:0] lrst;
    logic [1:0] hs_en_l;
    rtm_hs_s stage1;
    wire logic lrst_n_w = lrst[2];
    // the link clock stops after hs exit, so the de-skew path is cleared without it
    wire logic link_arst_n_w = resetn_in & hs_term_en_out;
    always_ff @(posedge hs_clk_in or negedge link_arst_n_w)
    begin
        if (!link_arst_n_w)
            lrst <= '0;
        else
            lrst <= {lrst[1:0], 1'b1};
    end
    always_ff @(posedge hs_clk_in or negedge lrst_n_w)
    begin
        if (!lrst_n_w)
        begin
            hs_en_l <= '0;
            stage1 <= '0;
            output_data_lanes_hs_out <= '0;
            output_clock_lane_en_out <= 1'b0;
        end
        else
        begin
            hs_en_l <= {hs_en_l[0], hs_term_en_out};
            stage1 <= input_data_lanes_hs_in;
            output_data_lanes_hs_out <= hs_en_l[1] ? stage1 : '0;
            output_clock_lane_en_out <= hs_en_l[1];
        end
    end

    // ----------------------------------------
    // I2C target and configuration bytes
    // ----------------------------------------
    logic scl_d;
    logic sda_d;
    rtm_i2c_e ist;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] txreg;
    logic [7:0] ptr;
    logic rw;
    logic [7:0] rx_equalizer_reg;
    logic [7:0] lp_edge_rate_reg;
    logic [7:0] tx_preemphasis_reg;
    wire logic scl_rise_w = scl_w & !scl_d;
    wire logic scl_fall_w = !scl_w & scl_d;
    wire logic start_w = scl_w & scl_d & sda_d & !sda_w;
    wire logic stop_w = scl_w & scl_d & !sda_d & sda_w;
    wire logic byte_w = scl_fall_w && bitcnt == 4'h8;
    wire logic addr_hit_w = shreg[7:1] == `RTM_I2C_ADDR;
    wire logic [7:0] rdata_w = ptr <= `RTM_OFS_ID_LAST ? ID_STRING[{ptr[2:0], 3'h0} +: 8] :
                               ptr == `RTM_OFS_REV ? DEV_REV :
                               ptr == `RTM_OFS_EQUALIZER ? rx_equalizer_reg :
                               ptr == `RTM_OFS_ERC ? lp_edge_rate_reg :
                               ptr == `RTM_OFS_TXCFG ? tx_preemphasis_reg : `RTM_RST_REG;
    wire logic wr_w = ist == RTM_I_WR && byte_w;
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            ist <= RTM_I_IDLE;
            bitcnt <= '0;
            shreg <= '0;
            txreg <= '0;
            ptr <= `RTM_PTR_RST;
            rw <= 1'b0;
            edge_rate_strap_data_pin_oe_out <= 1'b0;
        end
        else
        begin
            scl_d <= scl_w;
            sda_d <= sda_w;
            if (scl_rise_w)
            begin
                shreg <= {shreg[6:0], sda_w};
                bitcnt <= bitcnt + 4'h1;
            end
            if (!strap_done || stop_w)
            begin
                ist <= RTM_I_IDLE;
                edge_rate_strap_data_pin_oe_out <= 1'b0;
            end
            else if (start_w)
            begin
                ist <= RTM_I_ADDR;
                bitcnt <= '0;
                edge_rate_strap_data_pin_oe_out <= 1'b0;
            end
            else if (scl_fall_w)
            begin
                case (ist)
                    RTM_I_ADDR, RTM_I_SUB, RTM_I_WR:
                        if (bitcnt == 4'h8)
                        begin
                            bitcnt <= '0;
                            rw <= ist == RTM_I_ADDR ? shreg[0] : rw;
                            ist <= ist == RTM_I_ADDR ? (addr_hit_w ? RTM_I_AACK : RTM_I_IDLE) :
                                   ist == RTM_I_SUB ? RTM_I_SACK : RTM_I_WACK;
                            edge_rate_strap_data_pin_oe_out <= ist != RTM_I_ADDR || addr_hit_w;
                            if (ist == RTM_I_SUB)
                                ptr <= shreg;
                            else if (ist == RTM_I_WR)
                                ptr <= ptr + 8'h1;
                        end
                    RTM_I_AACK, RTM_I_RACK:
                        if (ist == RTM_I_AACK ? rw : !shreg[0])
                        begin
                            ist <= RTM_I_RD;
                            bitcnt <= '0;
                            txreg <= rdata_w;
                            edge_rate_strap_data_pin_oe_out <= !rdata_w[7];
                        end
                        else
                        begin
                            ist <= ist == RTM_I_AACK ? RTM_I_SUB : RTM_I_IDLE;
                            bitcnt <= '0; // the ack clock pulse must not count into the sub-address
                            edge_rate_strap_data_pin_oe_out <= 1'b0;
                        end
                    RTM_I_SACK, RTM_I_WACK:
                    begin
                        ist <= RTM_I_WR;
                        bitcnt <= '0;
                        edge_rate_strap_data_pin_oe_out <= 1'b0;
                    end
                    RTM_I_RD:
                        if (bitcnt == 4'h8)
                        begin
                            ist <= RTM_I_RACK;
                            ptr <= ptr + 8'h1;
                            edge_rate_strap_data_pin_oe_out <= 1'b0;
                        end
                        else
                        begin
                            txreg <= {txreg[6:0], 1'b0};
                            edge_rate_strap_data_pin_oe_out <= !txreg[6];
                        end
                    default: ist <= RTM_I_IDLE;
                endcase
            end
        end
    end
    assign edge_rate_strap_data_pin_out = 1'b0;

    // strap load and I2C writes share one process; writes wait for strap_done
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rx_equalizer_reg <= `RTM_RST_REG;
            lp_edge_rate_reg <= `RTM_RST_REG;
            tx_preemphasis_reg <= `RTM_RST_REG;
        end
        else if (strap_load_w)
        begin
            rx_equalizer_reg <= {4'h0, eq_code_w, eq_code_w};
            lp_edge_rate_reg <= {`RTM_LPERC_18NS, lperc_w, 2'h0, hserc_w};
            tx_preemphasis_reg <= {6'h0, swing_w, pre_w};
        end
        else if (wr_w)
        begin
            if (ptr == `RTM_OFS_EQUALIZER)
                rx_equalizer_reg <= shreg & `RTM_EQUALIZER_MASK;
            if (ptr == `RTM_OFS_ERC)
                lp_edge_rate_reg <= shreg & `RTM_ERC_MASK;
            if (ptr == `RTM_OFS_TXCFG)
                tx_preemphasis_reg <= shreg & `RTM_TXCFG_MASK;
        end
    end
    assign rx_equalizer_out = rx_equalizer_reg[3:0];
    assign hs_edge_rate_out = lp_edge_rate_reg[1:0];
    assign lp_edge_rate_out = lp_edge_rate_reg[7:4];
    assign tx_preemphasis_out = tx_preemphasis_reg[1:0];

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_eq_strap;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        strap_load_w |=> rx_equalizer_reg[1:0] == $past(eq_code_w) && strap_done;
    endproperty
    a_eq_strap: assert property (p_eq_strap) else $error("eq strap not loaded");
    property p_hserc;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        strap_load_w && erc_lvl_w == 2'h1 |=> hs_edge_rate_out == 2'h1;
    endproperty
    a_hserc: assert property (p_hserc) else $error("hs edge rate strap wrong");
    property p_pre;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        strap_load_w |=> tx_preemphasis_out[0] == (pre_lvl_w == 2'h2);
    endproperty
    a_pre: assert property (p_pre) else $error("pre-emphasis strap wrong");
    property p_hs_enter;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        mode == RTM_HSRQ && lane0_w == `RTM_LP00 |=> hs_term_en_out && mode == RTM_HS;
    endproperty
    a_hs_enter: assert property (p_hs_enter) else $error("hs entry missed");
    property p_hs_exit;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        mode == RTM_HS && lane0_w == `RTM_LP11 |=> mode == RTM_LP && !hs_term_en_out;
    endproperty
    a_hs_exit: assert property (p_hs_exit) else $error("hs exit late");
    property p_ulps_from_lp;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        $rose(mode == RTM_ULPS) |-> $past(mode) == RTM_ESC3 && !hs_logic_en_out;
    endproperty
    a_ulps_from_lp: assert property (p_ulps_from_lp) else $error("bad ulps entry");
    property p_latency;
        @(posedge hs_clk_in) disable iff (!lrst_n_w)
        hs_en_l[1] && $past(hs_en_l[1]) |-> output_data_lanes_hs_out == $past(input_data_lanes_hs_in, 2);
    endproperty
    a_latency: assert property (p_latency) else $error("de-skew latency wrong");
    property p_addr_ack;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        ist == RTM_I_ADDR && byte_w && !addr_hit_w |=> !edge_rate_strap_data_pin_oe_out;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("foreign address acked");
    property p_rev;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        mode == RTM_TA1 && lane0_w == `RTM_LP00 |=> ##1 input_lane_zero_oe_out && !output_lane_zero_oe_out;
    endproperty
    a_rev: assert property (p_rev) else $error("reverse lane not turned");
    c_hs: cover property (@(posedge clk_sys_in) mode == RTM_HSRQ ##1 mode == RTM_HS);
    c_ulps: cover property (@(posedge clk_sys_in) mode == RTM_ESC3 ##1 mode == RTM_ULPS);
    c_read: cover property (@(posedge clk_sys_in) ist == RTM_I_RACK ##[1:900] ist == RTM_I_RD);
endmodule : rtm_retimer

// *** rtm_map.svh ***
// Purpose: offsets, reset values and counts of the retimer control block
// Assumes: included by its bare name
// Notes: register bytes are eight bits wide
`ifndef RTM_MAP_SVH
`define RTM_MAP_SVH
`define RTM_I2C_ADDR 7'h6C
`define RTM_OFS_ID_LAST 8'h07
`define RTM_OFS_REV 8'h08
`define RTM_OFS_EQUALIZER 8'h09
`define RTM_OFS_ERC 8'h0A
`define RTM_OFS_TXCFG 8'h0B
`define RTM_EQUALIZER_MASK 8'h0F
`define RTM_ERC_MASK 8'hF3
`define RTM_TXCFG_MASK 8'h03
`define RTM_RST_REG 8'h00
`define RTM_PTR_RST 8'h00
`define RTM_STRAP_SETTLE 2'h2
`define RTM_LP11 2'h3
`define RTM_LP10 2'h2
`define RTM_LP01 2'h1
`define RTM_LP00 2'h0
`define RTM_EQ_0DB 2'h0
`define RTM_EQ_2P5DB 2'h1
`define RTM_EQ_5DB 2'h3
`define RTM_LPERC_18NS 2'h0
`define RTM_LPERC_21NS 2'h1
`define RTM_LPERC_27NS 2'h3
`define RTM_HSERC_200PS 2'h0
`define RTM_HSERC_150PS 2'h1
`define RTM_HSERC_250PS 2'h2
`endif

// *** rtm_pkg.sv ***
// Purpose: types shared by the retimer control block
// Assumes: nothing
// Notes: lane bundles carry p in bit 1 and n in bit 0 of each pair
package rtm_pkg;
    typedef enum logic [3:0] {
        RTM_LP = 4'h0, RTM_HSRQ = 4'h1, RTM_HS = 4'h3, RTM_ESC1 = 4'h2,
        RTM_ESC2 = 4'h6, RTM_ESC3 = 4'h7, RTM_ULPS = 4'h5, RTM_TA1 = 4'h4,
        RTM_REV = 4'hC, RTM_REVX = 4'hD
    } rtm_mode_e;
    typedef enum logic [3:0] {
        RTM_I_IDLE = 4'h0, RTM_I_ADDR = 4'h1, RTM_I_AACK = 4'h3, RTM_I_SUB = 4'h2,
        RTM_I_SACK = 4'h6, RTM_I_WR = 4'h7, RTM_I_WACK = 4'h5, RTM_I_RD = 4'h4,
        RTM_I_RACK = 4'hC
    } rtm_i2c_e;
    typedef struct packed {
        logic [3:0][1:0] lane;
    } rtm_lp_s;
    typedef struct packed {
        logic [3:0][1:0] lane;
    } rtm_hs_s;
endpackage : rtm_pkg

// *** rtm_link_model.sv ***
// Purpose: far-side source of the forwarded HS clock and HS lane bits
// Assumes: the clock stands still outside HS bursts
// Notes: idle data flips each step so a stale value never looks valid
`timescale 1ns/10ps
module rtm_link_model (
    input wire logic run_in, // burst on
    input wire logic [7:0] data_in, // bits to send
    output logic hs_clk_out, // forwarded clock
    output rtm_pkg::rtm_hs_s hs_data_out // HS lane bits
);
    import rtm_pkg::*;
    initial
    begin
        hs_clk_out = 1'b0;
        hs_data_out = '0;
        #3;
        forever
        begin
            #16;
            if (run_in)
                hs_clk_out = ~hs_clk_out;
            if (run_in && !hs_clk_out)
                hs_data_out = data_in;
            else if (!run_in)
                hs_data_out = ~hs_data_out;
        end
    end
endmodule : rtm_link_model

// *** tb_rtm_retimer.sv ***
// Purpose: self-checking bench of the retimer control block
// Assumes: inputs change on the falling clock edge
// Notes: I2C runs far above 100 kHz to keep the run short
`timescale 1ns/10ps
module tb_rtm_retimer;
    import rtm_pkg::*;
    logic clk, rst_n, scl, sda_m, run, a, ok, te, hl, soe, ooe, ioe, ce;
    logic [7:0] ln, rd;
    logic [1:0] eq, erc, sw, pre, hser, pe, ck, iz, rv;
    logic [3:0] eqo, lper;
    int err_count, tests_run;
    rtm_lp_s lpo;
    rtm_hs_s hso, hsi;
    rtm_mode_e md;
    logic hck;
    wire sda = sda_m & ~soe;
    rtm_link_model i_rtm_link_model (.run_in(run), .data_in(8'hA5), .hs_clk_out(hck), .hs_data_out(hsi));
    rtm_retimer i_rtm_retimer (.clk_sys_in(clk), .resetn_in(rst_n), .hs_clk_in(hck), .eq_strap_level_in(eq),
        .erc_strap_level_in(erc), .swing_strap_pin_in(sw), .preemph_strap_pin_hi_in(pre),
        .equalizer_strap_clock_pin_in(scl), .edge_rate_strap_data_pin_in(sda), .edge_rate_strap_data_pin_out(),
        .edge_rate_strap_data_pin_oe_out(soe), .input_data_lanes_lp_in(ln), .input_clock_lane_lp_in(2'h3),
        .output_lane_zero_lp_in(rv), .output_data_lanes_lp_out(lpo), .output_lane_zero_oe_out(ooe),
        .output_clock_lane_lp_out(ck), .input_lane_zero_lp_out(iz), .input_lane_zero_oe_out(ioe),
        .input_data_lanes_hs_in(hsi), .output_data_lanes_hs_out(hso), .output_clock_lane_en_out(ce),
        .hs_term_en_out(te), .hs_logic_en_out(hl), .rx_equalizer_out(eqo), .hs_edge_rate_out(hser),
        .lp_edge_rate_out(lper), .tx_preemphasis_out(pe), .mode_out(md));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e)
        begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic ph(input logic c, input logic d); // one third of a bit
        @(negedge clk);
        scl = c;
        sda_m = d;
        repeat (6) @(negedge clk);
    endtask : ph
    task automatic xb(input logic [7:0] d, input logic am, output logic [7:0] r, output logic ak);
        for (int i = 8; i >= 0; i--)
        begin
            ph(1'b0, (i > 0) ? d[i - 1] : am);
            ph(1'b1, (i > 0) ? d[i - 1] : am);
            if (i > 0) r[i - 1] = sda;
            else ak = sda;
            ph(1'b0, (i > 0) ? d[i - 1] : am);
        end
    endtask : xb
    task automatic se(input logic stop); // stop or start condition
        ph(!stop, !stop);
        ph(1'b1, !stop);
        ph(1'b1, stop);
    endtask : se
    task automatic wb(input logic [7:0] d, input logic e); // byte out, ack checked
        xb(d, 1'b1, rd, a);
        chk(8'(a), 8'(e));
    endtask : wb
    task automatic lp0(input logic [1:0] v, input rtm_mode_e m, input logic c);
        @(negedge clk);
        ln[1:0] = v;
        for (int i = 0; i < 20 && md !== m; i++) @(negedge clk);
        if (c)
            chk(8'(md), 8'(m));
        if (c && md !== m)
            complete_run();
    endtask : lp0
    task automatic complete_run;
        $display("counts: %0d compared, %0d mismatched", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    initial
    begin
        // pre-emphasis strap left low: the bench channel is low-loss
        {rst_n, run, err_count, tests_run, ln, eq, erc, sw, pre} = {2'b0, 64'h0, 8'hFF, 8'h7C};
        {scl, sda_m, rv} = 4'hF;
        repeat (12) @(negedge clk);
        chk(lpo, 8'h00);
        chk(8'(ooe), 8'h01);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        chk(8'(eqo), 8'h05);
        chk(8'(hser), 8'h02);
        chk(8'(pe), 8'h02);
        chk(8'(lper), 8'h00);
        chk(lpo, 8'hFF);
        chk(8'(ck), 8'h03);
        $display("test done: straps");
        se(0); wb(8'hD8, 0); wb(8'h09, 0); wb(8'h0F, 0); se(1);
        chk(8'(eqo), 8'h0F);
        se(0); wb(8'hD8, 0); wb(8'h08, 0); se(1);
        se(0); wb(8'hD9, 0);
        xb(8'hFF, 1'b0, rd, ok);
        chk(rd, 8'h01);
        xb(8'hFF, 1'b1, rd, ok);
        chk(rd, 8'h0F);
        se(1);
        se(0); wb(8'hB0, 1); se(1);
        $display("test done: i2c");
        lp0(2'h1, RTM_HS, 0);
        lp0(2'h0, RTM_HS, 1);
        chk(8'(te), 8'h01);
        run = 1'b1;
        repeat (40) @(negedge clk);
        chk(hso, 8'hA5);
        chk(8'(ce), 8'h01);
        chk(lpo, 8'h00);
        run = 1'b0;
        lp0(2'h3, RTM_LP, 1);
        chk(8'(te), 8'h00);
        chk(hso, 8'h00);
        chk(8'(ce), 8'h00);
        $display("test done: hs");
        lp0(2'h2, RTM_ULPS, 0);
        lp0(2'h0, RTM_ULPS, 0);
        lp0(2'h1, RTM_ULPS, 0);
        lp0(2'h0, RTM_ULPS, 1);
        chk(8'(hl), 8'h00);
        se(0);
        wb(8'hD8, 0);
        se(1);
        lp0(2'h3, RTM_LP, 1);
        $display("test done: ulps");
        lp0(2'h2, RTM_REV, 0);
        lp0(2'h0, RTM_REV, 0);
        lp0(2'h2, RTM_REV, 0);
        lp0(2'h0, RTM_REV, 1);
        repeat (2) @(negedge clk);
        chk(8'({ioe, ooe, iz}), 8'h0B);
        rv = 2'h2;
        repeat (5) @(negedge clk);
        rv = 2'h0;
        repeat (5) @(negedge clk);
        chk(8'({md, ioe, ooe}), 8'h01);
        $display("test done: reverse");
        rst_n = 1'b0;
        {eq, erc, sw, pre} = 8'hD3;
        repeat (4) @(negedge clk);
        chk(lpo, 8'h00);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        chk({eqo, hser, pe}, 8'hF7);
        chk(8'(lper), 8'h03);
        chk(lpo, 8'hFC);
        $display("test done: reset");
        complete_run();
    end
endmodule : tb_rtm_retimer
